// *** design/adc_ctrl.v ***
// Channel select and control/status registers of the on-chip 10-bit converter, with prescaler and sequencer.
// Assumes a single-cycle register port, a conversion core that returns a result on conv_result_in,
// and trigger sources from logic on the same clock.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_map.vh"
module adc_ctrl (
   input  wire       clk,
   input  wire       rst,
   input  wire [2:0] addr,
   input  wire [7:0] wdata,
   input  wire       wr,
   input  wire       rd,
   output reg  [7:0] rdata,
   input  wire       global_irq_en,
   input  wire       irq_vector_ack,
   input  wire [6:0] trigger_in,
   input  wire [9:0] conv_result_in,
   output reg        conv_power_on,
   output reg        conv_clk_en,
   output reg        conv_sample,
   output reg        conv_init,
   output reg  [1:0] reference_sel,
   output reg  [4:0] channel_sel,
   output reg  [2:0] pos_input,
   output reg  [2:0] neg_input,
   output reg        diff_mode,
   output reg  [1:0] gain_sel,
   output reg        irq_req
);
   localparam S_OFF  = 3'b001;
   localparam S_IDLE = 3'b010;
   localparam S_BUSY = 3'b100;

   reg [7:0] chsel_ff;
   reg [7:0] csra_ff;
   reg [2:0] trig_src_ff;
   reg [2:0] state_ff;
   reg       first_ff;
   reg [4:0] cyc_ff;
   reg [6:0] div_ff;
   reg [9:0] result_ff;
   reg       locked_ff;
   reg       pend_ff;
   reg       trig_prev_ff;
   reg [7:0] nxt_rdata;
   reg [2:0] nxt_state;

   // Gain code for a differential channel code.
   function [1:0] gain_of;
      input [4:0] c;
      begin
         if (c[4])
            gain_of = `GAIN_1X;
         else if (c[1])
            gain_of = `GAIN_200X;
         else
            gain_of = `GAIN_10X;
      end
   endfunction

   // Routing for a channel code, packed as {diff, gain, positive input, negative input}.
   // Spelled out code by code so each row can be held against the channel table.
   function [8:0] route_of;
      input [4:0] c;
      begin
         case (c)
            5'h00:   route_of = {1'b0, `GAIN_1X, 3'h0, 3'h0};
            5'h01:   route_of = {1'b0, `GAIN_1X, 3'h1, 3'h0};
            5'h02:   route_of = {1'b0, `GAIN_1X, 3'h2, 3'h0};
            5'h03:   route_of = {1'b0, `GAIN_1X, 3'h3, 3'h0};
            5'h04:   route_of = {1'b0, `GAIN_1X, 3'h4, 3'h0};
            5'h05:   route_of = {1'b0, `GAIN_1X, 3'h5, 3'h0};
            5'h06:   route_of = {1'b0, `GAIN_1X, 3'h6, 3'h0};
            5'h07:   route_of = {1'b0, `GAIN_1X, 3'h7, 3'h0};
            5'h08:   route_of = {1'b1, gain_of(c), 3'h0, 3'h0};
            5'h09:   route_of = {1'b1, gain_of(c), 3'h1, 3'h0};
            5'h0a:   route_of = {1'b1, gain_of(c), 3'h0, 3'h0};
            5'h0b:   route_of = {1'b1, gain_of(c), 3'h1, 3'h0};
            5'h0c:   route_of = {1'b1, gain_of(c), 3'h2, 3'h2};
            5'h0d:   route_of = {1'b1, gain_of(c), 3'h3, 3'h2};
            5'h0e:   route_of = {1'b1, gain_of(c), 3'h2, 3'h2};
            5'h0f:   route_of = {1'b1, gain_of(c), 3'h3, 3'h2};
            5'h10:   route_of = {1'b1, gain_of(c), 3'h0, 3'h1};
            5'h11:   route_of = {1'b1, gain_of(c), 3'h1, 3'h1};
            5'h12:   route_of = {1'b1, gain_of(c), 3'h2, 3'h1};
            5'h13:   route_of = {1'b1, gain_of(c), 3'h3, 3'h1};
            5'h14:   route_of = {1'b1, gain_of(c), 3'h4, 3'h1};
            5'h15:   route_of = {1'b1, gain_of(c), 3'h5, 3'h1};
            5'h16:   route_of = {1'b1, gain_of(c), 3'h6, 3'h1};
            5'h17:   route_of = {1'b1, gain_of(c), 3'h7, 3'h1};
            5'h18:   route_of = {1'b1, gain_of(c), 3'h0, 3'h2};
            5'h19:   route_of = {1'b1, gain_of(c), 3'h1, 3'h2};
            5'h1a:   route_of = {1'b1, gain_of(c), 3'h2, 3'h2};
            5'h1b:   route_of = {1'b1, gain_of(c), 3'h3, 3'h2};
            5'h1c:   route_of = {1'b1, gain_of(c), 3'h4, 3'h2};
            5'h1d:   route_of = {1'b1, gain_of(c), 3'h5, 3'h2};
            // Bandgap and ground have no pin; the core sees them through channel_sel.
            default: route_of = {1'b0, `GAIN_1X, 3'h0, 3'h0};
         endcase
      end
   endfunction

   // Divider bits that must all be one for a converter tick; codes 0 and 1 both divide by 2.
   function [6:0] div_mask_of;
      input [2:0] code;
      begin
         case (code)
            3'h0:    div_mask_of = 7'h01;
            3'h1:    div_mask_of = 7'h01;
            3'h2:    div_mask_of = 7'h03;
            3'h3:    div_mask_of = 7'h07;
            3'h4:    div_mask_of = 7'h0f;
            3'h5:    div_mask_of = 7'h1f;
            3'h6:    div_mask_of = 7'h3f;
            3'h7:    div_mask_of = 7'h7f;
            default: div_mask_of = 7'h01;
         endcase
      end
   endfunction

   wire wr_chsel = wr && (addr == `ADDR_CHANNEL_SELECT);
   wire wr_csra  = wr && (addr == `ADDR_CONTROL_STATUS);
   wire en       = csra_ff[`BIT_ENABLE];
   wire en_next  = wr_csra ? wdata[`BIT_ENABLE] : en;

   wire [6:0] div_mask = div_mask_of(csra_ff[2:0]);
   // The divider runs free while enabled, so the first tick of a conversion may come up to one period early.
   wire       tick     = en && ((div_ff & div_mask) == div_mask);

   wire [4:0] conv_len = first_ff ? `CONV_FIRST_CYCLES : `CONV_NORMAL_CYCLES;
   wire       finish   = (state_ff == S_BUSY) && tick && (cyc_ff == conv_len - 5'd1);

   wire trig_sel = (trig_src_ff == `TRIG_FREE_RUN) ? 1'b0 : trigger_in[trig_src_ff - 3'h1];
   wire trig_edge = csra_ff[`BIT_AUTO_TRIG] && trig_sel && !trig_prev_ff;
   wire free_run  = csra_ff[`BIT_AUTO_TRIG] && (trig_src_ff == `TRIG_FREE_RUN);
   wire sw_start  = wr_csra && wdata[`BIT_START] && wdata[`BIT_ENABLE];
   // A start is taken only while the converter stays enabled, so a trigger meeting a disabling write is dropped.
   wire go = en_next &&
             ((state_ff == S_IDLE && (sw_start || trig_edge)) || (state_ff == S_OFF && sw_start) ||
              (finish && free_run));

   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         S_OFF: begin
            if (sw_start)
               nxt_state = S_BUSY;
            else if (en_next)
               nxt_state = S_IDLE;
            else
               nxt_state = S_OFF;
         end
         S_IDLE: begin
            if (!en_next)
               nxt_state = S_OFF;
            else if (go)
               nxt_state = S_BUSY;
            else
               nxt_state = S_IDLE;
         end
         S_BUSY: begin
            // Clearing the enable aborts a running conversion without setting the done flag, unless the clear meets the finishing tick.
            if (!en_next)
               nxt_state = S_OFF;
            else if (finish && !go)
               nxt_state = S_IDLE;
            else
               nxt_state = S_BUSY;
         end
         default: nxt_state = S_OFF;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         state_ff <= S_OFF;
         first_ff <= 1'b1;
         cyc_ff <= 5'd0;
         div_ff <= 7'h00;
      end else begin
         state_ff <= nxt_state;
         div_ff <= (en && state_ff != S_OFF) ? div_ff + 7'h01 : 7'h00;
         if (!en_next)
            first_ff <= 1'b1;
         else if (finish)
            first_ff <= 1'b0;
         if (nxt_state == S_BUSY && (state_ff != S_BUSY || finish))
            cyc_ff <= 5'd0;
         else if (state_ff == S_BUSY && tick)
            cyc_ff <= cyc_ff + 5'd1;
      end
   end

   // Registers and status.
   always @(posedge clk) begin
      if (rst) begin
         chsel_ff <= `CHSEL_RESET;
         csra_ff <= `CSRA_RESET;
         trig_src_ff <= `TRIG_RESET;
         result_ff <= 10'h000;
         locked_ff <= 1'b0;
         pend_ff <= 1'b0;
         trig_prev_ff <= 1'b0;
      end else begin
         trig_prev_ff <= trig_sel;
         if (wr_chsel)
            chsel_ff <= wdata;
         if (wr && addr == `ADDR_TRIGGER_SOURCE)
            trig_src_ff <= wdata[2:0];
         if (wr_csra) begin
            csra_ff[7] <= wdata[7];
            csra_ff[5] <= wdata[5];
            csra_ff[3:0] <= wdata[3:0];
         end
         csra_ff[`BIT_START] <= (nxt_state == S_BUSY);
         if (rd && addr == `ADDR_RESULT_LOW)
            locked_ff <= 1'b1;
         else if (rd && addr == `ADDR_RESULT_HIGH)
            locked_ff <= 1'b0;
         // A finished result waiting on the lock is committed once the high byte is read.
         if (finish)
            pend_ff <= 1'b1;
         if ((finish || pend_ff) && !locked_ff) begin
            result_ff <= conv_result_in;
            pend_ff <= 1'b0;
         end
         if (finish)
            csra_ff[`BIT_DONE_FLAG] <= 1'b1;
         else if (irq_vector_ack || (wr_csra && wdata[`BIT_DONE_FLAG]))
            csra_ff[`BIT_DONE_FLAG] <= 1'b0;
      end
   end

   // The write that meets a start may carry a new selection, so the bus value is taken directly then.
   wire [1:0] sel_ref   = wr_chsel ? wdata[7:6] : chsel_ff[7:6];
   wire [4:0] sel_chan  = wr_chsel ? wdata[4:0] : chsel_ff[4:0];
   wire [8:0] sel_route = route_of(sel_chan);

   // Analog selection is latched at conversion start so mid-conversion writes wait.
   always @(posedge clk) begin
      if (rst) begin
         reference_sel <= `REF_EXT_PIN;
         channel_sel <= 5'h00;
         pos_input <= 3'h0;
         neg_input <= 3'h0;
         diff_mode <= 1'b0;
         gain_sel <= `GAIN_1X;
      end else if (go) begin
         reference_sel <= sel_ref;
         channel_sel <= sel_chan;
         diff_mode <= sel_route[8];
         gain_sel <= sel_route[7:6];
         pos_input <= sel_route[5:3];
         neg_input <= sel_route[2:0];
      end
   end

   always @* begin
      nxt_rdata = 8'h00;
      case (addr)
         `ADDR_CHANNEL_SELECT: nxt_rdata = chsel_ff;
         `ADDR_CONTROL_STATUS: nxt_rdata = csra_ff;
         `ADDR_RESULT_LOW:     nxt_rdata = chsel_ff[`BIT_LEFT_ALIGN] ? {result_ff[1:0], 6'h00} : result_ff[7:0];
         `ADDR_RESULT_HIGH:    nxt_rdata = chsel_ff[`BIT_LEFT_ALIGN] ? result_ff[9:2] : {6'h00, result_ff[9:8]};
         `ADDR_TRIGGER_SOURCE: nxt_rdata = {5'h00, trig_src_ff};
         default:              nxt_rdata = 8'h00;
      endcase
   end

   always @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
         irq_req <= 1'b0;
         conv_power_on <= 1'b0;
         conv_clk_en <= 1'b0;
         conv_sample <= 1'b0;
         conv_init <= 1'b0;
      end else begin
         rdata <= rd ? nxt_rdata : 8'h00;
         irq_req <= csra_ff[`BIT_DONE_FLAG] && csra_ff[`BIT_IRQ_EN] && global_irq_en;
         conv_power_on <= en_next;
         conv_clk_en <= tick && state_ff == S_BUSY && en_next;
         conv_sample <= go;
         conv_init <= go && (first_ff || state_ff == S_OFF);
      end
   end
endmodule // adc_ctrl
`default_nettype wire

// *** inc/adc_ctrl_map.vh ***
// Register offsets, field positions, reset values and timing counts for the converter control block.
// Included by the design file by bare name; definitions only.
`ifndef ADC_CTRL_MAP_VH
`define ADC_CTRL_MAP_VH
`define ADDR_CHANNEL_SELECT 3'h0
`define ADDR_CONTROL_STATUS 3'h1
`define ADDR_RESULT_LOW     3'h2
`define ADDR_RESULT_HIGH    3'h3
`define ADDR_TRIGGER_SOURCE 3'h4
`define CHSEL_RESET         8'h00
`define CSRA_RESET          8'h00
`define TRIG_RESET          3'h0
`define BIT_ENABLE          7
`define BIT_START           6
`define BIT_AUTO_TRIG       5
`define BIT_DONE_FLAG       4
`define BIT_IRQ_EN          3
`define BIT_LEFT_ALIGN      5
`define REF_EXT_PIN         2'h0
`define REF_SUPPLY          2'h1
`define REF_RESERVED        2'h2
`define REF_INTERNAL        2'h3
`define CH_BANDGAP          5'h1e
`define CH_GROUND           5'h1f
`define CH_DIFF_FIRST       5'h08
`define GAIN_1X             2'h0
`define GAIN_10X            2'h1
`define GAIN_200X           2'h2
`define CONV_FIRST_CYCLES   5'd25
`define CONV_NORMAL_CYCLES  5'd13
`define TRIG_FREE_RUN       3'h0
`endif

// *** verif/adc_ctrl_props.sv ***
// Checker for the converter control block, watching its ports only.
// Assumes one clock and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_props (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       global_irq_en,
   input wire logic       conv_power_on,
   input wire logic       conv_clk_en,
   input wire logic       conv_sample,
   input wire logic       conv_init,
   input wire logic [1:0] reference_sel,
   input wire logic [4:0] channel_sel,
   input wire logic       irq_req
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence tick_s;
      conv_clk_en;
   endsequence
   sequence start_s;
      conv_sample || $past(conv_sample);
   endsequence
   sample_power_a: assert property (conv_sample |-> conv_power_on) else $error("sample while off");
   tick_power_a: assert property (tick_s |-> conv_power_on) else $error("tick while off");
   init_start_a: assert property (conv_init |-> conv_sample) else $error("init without start");
   tick_gap_a: assert property (tick_s |=> !conv_clk_en) else $error("ticks too close");
   chan_hold_a: assert property ($changed(channel_sel) |-> start_s) else $error("channel moved");
   ref_hold_a: assert property ($changed(reference_sel) |-> start_s) else $error("reference moved");
   irq_cause_a: assert property (irq_req |-> $past(global_irq_en)) else $error("irq without global");
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00) else $error("data without read");
endmodule // adc_ctrl_props
bind adc_ctrl adc_ctrl_props u_props (.clk, .rst, .rd, .rdata, .global_irq_en, .conv_power_on,
   .conv_clk_en, .conv_sample, .conv_init, .reference_sel, .channel_sel, .irq_req);
`default_nettype wire

// *** verif/conv_core_model.sv ***
// Conversion core model: result encodes the selection in force at each tick.
// Assumes the sequencer samples the result in the finishing cycle.
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
   input  wire logic       clk,
   input  wire logic       conv_clk_en,
   input  wire logic [1:0] reference_sel,
   input  wire logic [4:0] channel_sel,
   output var  logic [9:0] conv_result_in
);
   initial conv_result_in = 10'h000;
   // The core holds its last result, as its output register does.
   always @(posedge clk) begin
      if (conv_clk_en) conv_result_in <= {reference_sel, 3'h5, channel_sel};
   end
endmodule // conv_core_model
`default_nettype wire

// *** verif/tb.sv ***
// Bench for adc_ctrl: register tasks and a core model.
// Assumes the single-cycle register port of the design.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic       clk = 0, rst = 1, wr = 0, rd = 0, gie = 0, ack = 0;
   logic [2:0] addr = 0;
   logic [7:0] wdata = 0, d;
   logic [6:0] trig = 0;
   wire  [9:0] res;
   wire  [7:0] rdata;
   wire  [1:0] rsel;
   wire  [4:0] csel;
   wire        pwr, cke, irq, dif;
   wire  [2:0] pin, nin;
   wire  [1:0] gsel;
   int         mismatches = 0, n_checks = 0, i, n;
   always #12.5 clk = ~clk;
   adc_ctrl DUT (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata, .global_irq_en(gie), .irq_vector_ack(ack),
      .trigger_in(trig), .conv_result_in(res), .conv_power_on(pwr), .conv_clk_en(cke), .conv_sample(),
      .conv_init(), .reference_sel(rsel), .channel_sel(csel), .pos_input(pin), .neg_input(nin), .diff_mode(dif),
      .gain_sel(gsel), .irq_req(irq));
   conv_core_model core (.clk, .conv_clk_en(cke), .reference_sel(rsel), .channel_sel(csel), .conv_result_in(res));
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task chk8(input logic [7:0] g, input logic [7:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %0t got %h exp %h", $time, g, e);
      end
   endtask
   task chk1(input logic g, input logic e);
      chk8({7'h00, g}, {7'h00, e});
   endtask
   task wr8(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task rd8(input logic [2:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 d = rdata;
   endtask
   // Polls the done flag; a flag that never comes ends the run.
   task poll;
      d = 0;
      for (i = 0; i < 1000 && d[4] !== 1; i++) rd8(1);
      if (i == 1000) begin
         mismatches++;
         end_of_test;
      end
   endtask
   task gap;
      n = 0;
      do begin
         @(posedge clk);
         #1 n++;
      end while (cke !== 1 && n < 300);
      if (cke !== 1) begin
         mismatches++;
         end_of_test;
      end
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 0;
      for (int a = 0; a < 6; a++) begin
         rd8(a[2:0]);
         chk8(d, 8'h00);
      end
      $display("reset test done");
      wr8(0, 8'hc9);
      wr8(1, 8'hc8);
      rd8(1);
      chk8(d, 8'hc8);
      wr8(0, 8'h00);
      #1 chk1(csel === 5'h09 && rsel === 2'h3, 1);
      chk8({gsel, pin, nin}, 8'h48);
      chk1(dif, 1);
      poll;
      chk1(i > 20, 1);
      chk8(d, 8'h98);
      chk1(irq, 0);
      @(posedge clk) gie <= 1;
      repeat (3) @(posedge clk);
      #1 chk1(irq, 1);
      @(posedge clk) ack <= 1;
      @(posedge clk) ack <= 0;
      repeat (3) @(posedge clk);
      #1 chk1(irq, 0);
      rd8(1);
      chk8(d, 8'h88);
      rd8(2);
      chk8(d, 8'ha9);
      rd8(3);
      chk8(d, 8'h03);
      wr8(0, 8'h20);
      rd8(2);
      chk8(d, 8'h40);
      rd8(3);
      chk8(d, 8'hea);
      $display("conversion test done");
      for (int c = 0; c < 8; c++) begin
         wr8(1, {5'h1a, c[2:0]});
         gap;
         gap;
         chk1(n == (c < 2 ? 2 : 1 << c), 1);
         poll;
      end
      wr8(1, 8'hd0);
      wr8(1, 8'h90);
      rd8(1);
      chk8(d, 8'hc0);
      wr8(1, 8'h10);
      #1 chk1(pwr, 0);
      repeat (60) @(posedge clk);
      rd8(1);
      chk8(d, 8'h00);
      wr8(4, 8'h01);
      wr8(1, 8'hb0);
      @(posedge clk) trig <= 7'h01;
      poll;
      chk8(d, 8'hb0);
      chk1(dif, 0);
      wr8(4, 8'h00);
      wr8(1, 8'hf0);
      poll;
      wr8(1, 8'hb0);
      rd8(1);
      chk8(d, 8'he0);
      poll;
      chk8(d, 8'hf0);
      $display("mode test done");
      end_of_test;
   end
endmodule // tb
`default_nettype wire
